// ---- cpu_exec_pkg.sv ----
// Constants and types for the instruction execution core.
// Assumes an APB master on the register side and zero-latency memories.
package cpu_exec_pkg;
  // ==========================================================
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SUM = 8'h08;
  localparam logic [7:0] REG_PTR1 = 8'h0C;
  localparam logic [7:0] REG_PTR2 = 8'h10;
  localparam logic [7:0] REG_BANK = 8'h14;
  localparam logic [7:0] REG_STACK = 8'h18;
  localparam logic [7:0] REG_PC = 8'h1C;
  localparam logic [7:0] REG_FLAGS = 8'h20;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [14:0] RST_PC = 15'h0000;
  // ==========================================================
  // Opcode classes (opcode bits 7:3)
  localparam logic [4:0] OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUBTRACT_WITH_CARRY = 5'h02;
  localparam logic [4:0] OP_AND = 5'h03, OP_OR = 5'h04, OP_XOR = 5'h05;
  localparam logic [4:0] OP_SKIP_UNLESS_EQUAL = 5'h06, OP_SKIP_UNLESS_UNEQUAL = 5'h07, OP_SKIP_UNLESS_GREATER = 5'h08;
  localparam logic [4:0] OP_LDA = 5'h09, OP_XCH = 5'h0A, OP_LDMI = 5'h0B;
  localparam logic [4:0] OP_SETB = 5'h0C, OP_CLRB = 5'h0D, OP_IFEQMD = 5'h0E;
  localparam logic [4:0] OP_MASK_SKIP_IF_ZERO = 5'h0F, OP_SKIP_UNLESS_POINTER_LOW_NIBBLE_DIFFERS = 5'h10, OP_DECREMENT_SKIP_ON_ZERO = 5'h11;
  localparam logic [4:0] OP_LDPTR = 5'h12, OP_LDREG = 5'h13, OP_ACC = 5'h14;
  localparam logic [4:0] OP_MISC = 5'h15, OP_FARJ = 5'h16, OP_PAGEJ = 5'h17;
  localparam logic [4:0] OP_SHORTJ = 5'h18, OP_CALL = 5'h19, OP_VIS = 5'h1A;
  // ==========================================================
  // Operand modes (opcode bits 2:0)
  localparam logic [2:0] MD_PTR1 = 3'h0, MD_PTR2 = 3'h1, MD_DIRECT = 3'h2;
  localparam logic [2:0] MD_IMM = 3'h3, MD_P1INC = 3'h4, MD_P1DEC = 3'h5;
  localparam logic [2:0] MD_P2INC = 3'h6, MD_P2DEC = 3'h7;
  // Sub-operations of OP_ACC and OP_MISC
  localparam logic [2:0] AC_CLR = 3'h0, AC_INC = 3'h1, AC_DEC = 3'h2;
  localparam logic [2:0] AC_LOAD_FROM_PROGRAM_TABLE = 3'h3, AC_DECIMAL_ADJUST = 3'h4, AC_RRC = 3'h5;
  localparam logic [2:0] AC_RLC = 3'h6, AC_SWAP = 3'h7;
  localparam logic [2:0] MS_SC = 3'h0, MS_RC = 3'h1, MS_IFC = 3'h2;
  localparam logic [2:0] MS_IFNC = 3'h3, MS_PUSH = 3'h4, MS_POP = 3'h5;
  localparam logic [2:0] MS_RET = 3'h6, MS_NOP = 3'h7;
  localparam logic [3:0] REG_PAGE = 4'hF;

  typedef enum logic [3:0] {
    PH_HALT, PH_DECODE, PH_EXT1, PH_EXT2, PH_LAUNCH, PH_MEMRD,
    PH_SKIP, PH_LOAD_FROM_PROGRAM_TABLE, PH_CALL2, PH_RET2, PH_VIS1, PH_VIS2
  } phase_t;
endpackage

// ---- cpu_exec_core.sv ----
// Multi-cycle 8-bit instruction decode and execute core with APB access.
// Assumes program and data memories answer combinationally to the
// registered address outputs, within the same clock cycle.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Add with or without carry, subtract with carry
// - Add with carry updates carry, half carry
// - Subtract with carry updates carry, half carry
// - AND, OR, XOR into sum register
// - AND immediate, skip when zero
// - False condition skips next instruction
// - Equal, unequal, greater compares; direct-immediate compare
// - Skip unless pointer low nibble differs
// - Decrement register byte, skip on zero
// - Set or clear memory bit 0..7
// - Exchange with pointer byte, post adjust
// - Loads, immediate store with post adjust
// - Table read from program memory page
// - Decimal adjust after carry add/subtract
// - Rotate left or right through carry
// - Swap sum register nibbles
// - Pop pre-increments, push post-decrements stack
// - Vector dispatch loads two-byte vector
// - Far jump loads all fifteen bits
// - Page jump replaces low twelve bits
// - Calls push counter, returns pop it
// - Page jump keeps upper three bits
// - Skipped instruction costs cycle per byte
module cpu_exec_core (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [14:0] pm_addr_out,
  input wire logic [7:0] pm_data_in,
  output logic [15:0] dm_addr_out,
  output logic dm_we_out,
  output logic [7:0] dm_wdata_out,
  input wire logic [7:0] dm_rdata_in,
  input wire logic [14:0] vector_addr_in
);
  import cpu_exec_pkg::*;

  typedef struct packed {
    phase_t ph;
    logic run;
    logic [14:0] pc;
    logic [14:0] op_pc;
    logic [7:0] ir;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] ext;
    logic [1:0] rem;
    logic [7:0] sum;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] bank;
    logic [7:0] sp;
    logic cy;
    logic hc;
    logic global_irq_enable;
    logic last_sub;
    logic skip;
    logic [14:0] pm_addr;
    logic [15:0] dm_addr;
    logic dm_we;
    logic [7:0] dm_wdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t state_r, state_nxt;

  // Number of operand bytes following an opcode.
  function automatic logic [1:0] ext_bytes(input logic [7:0] op);
    logic [4:0] k;
    logic [2:0] m;
    begin
      k = op[7:3];
      m = op[2:0];
      if (k <= OP_XCH) begin
        ext_bytes = (m == MD_DIRECT || m == MD_IMM) ? 2'h1 : 2'h0;
      end else if (k == OP_LDMI) begin
        ext_bytes = (m == MD_DIRECT) ? 2'h2 : 2'h1;
      end else if (k == OP_IFEQMD || k == OP_LDREG || k == OP_FARJ ||
                   k == OP_PAGEJ || k == OP_CALL) begin
        ext_bytes = 2'h2;
      end else if (k == OP_ACC || k == OP_MISC || k > OP_SHORTJ) begin
        ext_bytes = 2'h0;
      end else begin
        ext_bytes = 2'h1;
      end
    end
  endfunction

  always_comb begin
    logic [4:0] cls;
    logic [2:0] md;
    logic [7:0] ea;
    logic [7:0] opnd;
    logic [7:0] imm;
    logic [8:0] full;
    logic [4:0] half;
    logic [7:0] tmp;
    logic [7:0] rdv;
    logic rd_needed;
    logic exec_now;
    logic go;
    logic [14:0] go_pc;
    logic [14:0] rel;
    logic [1:0] cnt;
    logic wr_ok;
    state_nxt = state_r;
    ea = 8'h00;
    opnd = 8'h00;
    rd_needed = 1'b0;
    exec_now = 1'b0;
    wr_ok = 1'b0;
    cls = state_r.ir[7:3];
    md = state_r.ir[2:0];
    imm = state_r.b1;
    full = 9'h000;
    half = 5'h00;
    tmp = 8'h00;
    rdv = 8'h00;
    go = 1'b0;
    go_pc = state_r.pc;
    rel = 15'h0000;
    cnt = ext_bytes(pm_data_in);
    state_nxt.dm_we = 1'b0;

    // ========================================================
    // Effective data address and operand source
    unique case (md)
      MD_PTR1, MD_P1INC, MD_P1DEC: ea = state_r.p1;
      MD_PTR2, MD_P2INC, MD_P2DEC: ea = state_r.p2;
      default: ea = state_r.b1;
    endcase
    if (cls == OP_SETB || cls == OP_CLRB || cls == OP_IFEQMD) begin
      ea = state_r.b1;
    end else if (cls == OP_DECREMENT_SKIP_ON_ZERO || cls == OP_LDREG) begin
      ea = {REG_PAGE, state_r.b1[3:0]};
    end else if (cls == OP_LDMI && md == MD_DIRECT) begin
      ea = state_r.b2;
    end else if (cls == OP_MISC) begin
      ea = state_r.sp + 8'h01;
    end
    rd_needed = (cls <= OP_XCH && md != MD_IMM) || cls == OP_SETB ||
                cls == OP_CLRB || cls == OP_IFEQMD || cls == OP_DECREMENT_SKIP_ON_ZERO ||
                (cls == OP_MISC && (md == MS_POP || md == MS_RET));
    exec_now = (state_r.ph == PH_MEMRD) ||
               (state_r.ph == PH_LAUNCH && !rd_needed);
    opnd = (state_r.ph == PH_MEMRD) ? dm_rdata_in : state_r.b1;

    // ========================================================
    // Sequencer
    unique case (state_r.ph)
      PH_HALT: begin
        if (state_r.run) begin
          go = 1'b1;
        end
      end
      PH_DECODE: begin
        state_nxt.op_pc = state_r.pc;
        state_nxt.ir = pm_data_in;
        if (state_r.skip) begin
          state_nxt.skip = 1'b0;
          state_nxt.pc = state_r.pc + 15'h0001 + {13'h0000, cnt};
          state_nxt.rem = cnt;
          state_nxt.ph = PH_SKIP;
          if (cnt == 2'h0) begin
            go = 1'b1;
            go_pc = state_r.pc + 15'h0001;
          end
        end else begin
          state_nxt.pc = state_r.pc + 15'h0001;
          state_nxt.ext = cnt;
          state_nxt.pm_addr = state_r.pc + 15'h0001;
          state_nxt.ph = (cnt == 2'h0) ? PH_LAUNCH : PH_EXT1;
        end
      end
      PH_SKIP: begin
        state_nxt.rem = state_r.rem - 2'h1;
        if (state_r.rem == 2'h1) begin
          go = 1'b1;
        end
      end
      PH_EXT1: begin
        state_nxt.b1 = pm_data_in;
        state_nxt.pc = state_r.pc + 15'h0001;
        state_nxt.pm_addr = state_r.pc + 15'h0001;
        state_nxt.ph = (state_r.ext == 2'h2) ? PH_EXT2 : PH_LAUNCH;
      end
      PH_EXT2: begin
        state_nxt.b2 = pm_data_in;
        state_nxt.pc = state_r.pc + 15'h0001;
        state_nxt.ph = PH_LAUNCH;
      end
      PH_LAUNCH: begin
        if (rd_needed) begin
          state_nxt.dm_addr = {state_r.bank, ea};
          state_nxt.ph = PH_MEMRD;
          if (cls == OP_MISC) begin
            state_nxt.sp = (md == MS_POP) ? ea : state_r.sp + 8'h02;
            state_nxt.dm_addr = {state_r.bank, state_r.sp + 8'h02};
            if (md == MS_POP) begin
              state_nxt.dm_addr = {state_r.bank, ea};
            end
          end
        end
      end
      PH_LOAD_FROM_PROGRAM_TABLE: begin
        state_nxt.sum = pm_data_in;
        go = 1'b1;
      end
      PH_CALL2: begin
        state_nxt.dm_we = 1'b1;
        state_nxt.dm_addr = {state_r.bank, state_r.sp - 8'h01};
        state_nxt.dm_wdata = {1'b0, state_r.pc[14:8]};
        state_nxt.sp = state_r.sp - 8'h02;
        go = 1'b1;
        go_pc = {state_r.b1[6:0], state_r.b2};
      end
      PH_RET2: begin
        go = 1'b1;
        go_pc = {dm_rdata_in[6:0], state_r.b2};
      end
      PH_VIS1: begin
        state_nxt.b1 = pm_data_in;
        state_nxt.pm_addr = state_r.pm_addr + 15'h0001;
        state_nxt.ph = PH_VIS2;
      end
      PH_VIS2: begin
        go = 1'b1;
        go_pc = {state_r.b1[6:0], pm_data_in};
      end
      default: begin
        state_nxt.ph = PH_HALT;
      end
    endcase

    // ========================================================
    // Execution of the collected instruction
    if (exec_now) begin
      go = 1'b1;
      unique case (cls)
        OP_ADD: state_nxt.sum = state_r.sum + opnd;
        OP_ADC, OP_SUBTRACT_WITH_CARRY: begin
          tmp = (cls == OP_SUBTRACT_WITH_CARRY) ? ~opnd : opnd;
          full = {1'b0, state_r.sum} + {1'b0, tmp} + {8'h00, state_r.cy};
          half = {1'b0, state_r.sum[3:0]} + {1'b0, tmp[3:0]} +
                 {4'h0, state_r.cy};
          state_nxt.sum = full[7:0];
          state_nxt.cy = full[8];
          state_nxt.hc = half[4];
          state_nxt.last_sub = (cls == OP_SUBTRACT_WITH_CARRY);
        end
        OP_AND: state_nxt.sum = state_r.sum & opnd;
        OP_OR: state_nxt.sum = state_r.sum | opnd;
        OP_XOR: state_nxt.sum = state_r.sum ^ opnd;
        OP_SKIP_UNLESS_EQUAL: state_nxt.skip = (state_r.sum != opnd);
        OP_SKIP_UNLESS_UNEQUAL: state_nxt.skip = (state_r.sum == opnd);
        OP_SKIP_UNLESS_GREATER: state_nxt.skip = !(state_r.sum > opnd);
        OP_IFEQMD: state_nxt.skip = (opnd != state_r.b2);
        OP_LDA: state_nxt.sum = opnd;
        OP_XCH: begin
          state_nxt.sum = opnd;
          state_nxt.dm_we = (md != MD_IMM);
          state_nxt.dm_addr = {state_r.bank, ea};
          state_nxt.dm_wdata = state_r.sum;
        end
        OP_LDMI, OP_LDREG: begin
          state_nxt.dm_we = 1'b1;
          state_nxt.dm_addr = {state_r.bank, ea};
          state_nxt.dm_wdata = (cls == OP_LDREG) ? state_r.b2 : imm;
        end
        OP_SETB, OP_CLRB: begin
          tmp = 8'h01 << md;
          state_nxt.dm_we = 1'b1;
          state_nxt.dm_addr = {state_r.bank, ea};
          state_nxt.dm_wdata = (cls == OP_SETB) ? (opnd | tmp) : (opnd & ~tmp);
        end
        OP_MASK_SKIP_IF_ZERO: state_nxt.skip = ((state_r.sum & imm) == 8'h00);
        OP_SKIP_UNLESS_POINTER_LOW_NIBBLE_DIFFERS: state_nxt.skip = (state_r.p1[3:0] == imm[3:0]);
        OP_DECREMENT_SKIP_ON_ZERO: begin
          tmp = opnd - 8'h01;
          state_nxt.dm_we = 1'b1;
          state_nxt.dm_addr = {state_r.bank, ea};
          state_nxt.dm_wdata = tmp;
          state_nxt.skip = (tmp == 8'h00);
        end
        OP_LDPTR: begin
          unique case (md[1:0])
            2'h0: state_nxt.p1 = imm;
            2'h1: state_nxt.p2 = imm;
            2'h2: state_nxt.sp = imm;
            default: state_nxt.bank = imm;
          endcase
        end
        OP_ACC: begin
          unique case (md)
            AC_CLR: state_nxt.sum = 8'h00;
            AC_INC: state_nxt.sum = state_r.sum + 8'h01;
            AC_DEC: state_nxt.sum = state_r.sum - 8'h01;
            AC_LOAD_FROM_PROGRAM_TABLE: begin
              go = 1'b0;
              state_nxt.pm_addr = {state_r.pc[14:8], state_r.sum};
              state_nxt.ph = PH_LOAD_FROM_PROGRAM_TABLE;
            end
            AC_DECIMAL_ADJUST: begin
              tmp = state_r.sum;
              if (!state_r.last_sub) begin
                if (state_r.hc || state_r.sum[3:0] > 4'h9) begin
                  tmp = tmp + 8'h06;
                end
                if (state_r.cy || state_r.sum > 8'h99) begin
                  tmp = tmp + 8'h60;
                end
              end else begin
                if (!state_r.hc) begin
                  tmp = tmp - 8'h06;
                end
                if (!state_r.cy) begin
                  tmp = tmp - 8'h60;
                end
              end
              state_nxt.sum = tmp;
            end
            AC_RRC: begin
              state_nxt.sum = {state_r.cy, state_r.sum[7:1]};
              state_nxt.cy = state_r.sum[0];
            end
            AC_RLC: begin
              state_nxt.sum = {state_r.sum[6:0], state_r.cy};
              state_nxt.cy = state_r.sum[7];
            end
            default: state_nxt.sum = {state_r.sum[3:0], state_r.sum[7:4]};
          endcase
        end
        OP_MISC: begin
          unique case (md)
            MS_SC: begin
              state_nxt.cy = 1'b1;
              state_nxt.hc = 1'b1;
            end
            MS_RC: begin
              state_nxt.cy = 1'b0;
              state_nxt.hc = 1'b0;
            end
            MS_IFC: state_nxt.skip = !state_r.cy;
            MS_IFNC: state_nxt.skip = state_r.cy;
            MS_PUSH: begin
              state_nxt.dm_we = 1'b1;
              state_nxt.dm_addr = {state_r.bank, state_r.sp};
              state_nxt.dm_wdata = state_r.sum;
              state_nxt.sp = state_r.sp - 8'h01;
            end
            MS_POP: state_nxt.sum = opnd;
            MS_RET: begin
              go = 1'b0;
              state_nxt.b2 = opnd;
              state_nxt.dm_addr = {state_r.bank, state_r.sp - 8'h01};
              state_nxt.ph = PH_RET2;
            end
            default: state_nxt.skip = 1'b0;
          endcase
        end
        OP_FARJ: go_pc = {state_r.b1[6:0], state_r.b2};
        OP_PAGEJ: go_pc = {state_r.op_pc[14:12], state_r.b1[3:0], state_r.b2};
        OP_SHORTJ: begin
          rel = state_r.op_pc + {{7{imm[7]}}, imm};
          if ($signed(imm) >= -8'sd31 && $signed(imm) <= 8'sd32 &&
              imm != 8'h01) begin
            go_pc = rel;
          end
        end
        OP_CALL: begin
          go = 1'b0;
          state_nxt.dm_we = 1'b1;
          state_nxt.dm_addr = {state_r.bank, state_r.sp};
          state_nxt.dm_wdata = state_r.pc[7:0];
          state_nxt.ph = PH_CALL2;
        end
        OP_VIS: begin
          go = 1'b0;
          state_nxt.pm_addr = vector_addr_in;
          state_nxt.ph = PH_VIS1;
        end
        default: go = 1'b1;
      endcase
      if (cls == OP_LDA || cls == OP_XCH || cls == OP_LDMI) begin
        unique case (md)
          MD_P1INC: state_nxt.p1 = state_r.p1 + 8'h01;
          MD_P1DEC: state_nxt.p1 = state_r.p1 - 8'h01;
          MD_P2INC: state_nxt.p2 = state_r.p2 + 8'h01;
          MD_P2DEC: state_nxt.p2 = state_r.p2 - 8'h01;
          default: state_nxt.p1 = state_nxt.p1;
        endcase
      end
    end

    // Next opcode fetch, or halt once the instruction completes.
    if (go) begin
      state_nxt.pc = go_pc;
      state_nxt.pm_addr = go_pc;
      state_nxt.ph = state_r.run ? PH_DECODE : PH_HALT;
    end

    // ========================================================
    // APB slave: read data captured in setup, zero wait access
    unique case (paddr_in)
      REG_CTRL: rdv = {7'h00, state_r.run};
      REG_STATUS: rdv = {6'h00, state_r.skip, state_r.ph == PH_HALT};
      REG_SUM: rdv = state_r.sum;
      REG_PTR1: rdv = state_r.p1;
      REG_PTR2: rdv = state_r.p2;
      REG_BANK: rdv = state_r.bank;
      REG_STACK: rdv = state_r.sp;
      REG_PC: rdv = state_r.pc[7:0];
      REG_FLAGS: rdv = {5'h00, state_r.global_irq_enable, state_r.hc, state_r.cy};
      default: rdv = 8'h00;
    endcase
    state_nxt.pready = psel_in && !penable_in;
    state_nxt.pslverr = psel_in && !penable_in && paddr_in > REG_FLAGS;
    if (psel_in && !penable_in) begin
      state_nxt.prdata = (paddr_in == REG_PC) ?
          {17'h00000, state_r.pc} : {24'h000000, rdv};
    end
    // Core registers only change while fully stopped.
    wr_ok = (state_r.ph == PH_HALT) && !state_r.run;
    if (psel_in && penable_in && state_r.pready && pwrite_in) begin
      unique case (paddr_in)
        REG_CTRL: state_nxt.run = pwdata_in[0];
        REG_SUM: state_nxt.sum = wr_ok ? pwdata_in[7:0] : state_nxt.sum;
        REG_PTR1: state_nxt.p1 = wr_ok ? pwdata_in[7:0] : state_nxt.p1;
        REG_PTR2: state_nxt.p2 = wr_ok ? pwdata_in[7:0] : state_nxt.p2;
        REG_BANK: state_nxt.bank = wr_ok ? pwdata_in[7:0] : state_nxt.bank;
        REG_STACK: state_nxt.sp = wr_ok ? pwdata_in[7:0] : state_nxt.sp;
        REG_PC: state_nxt.pc = wr_ok ? pwdata_in[14:0] : state_nxt.pc;
        REG_FLAGS: begin
          if (wr_ok) begin
            state_nxt.cy = pwdata_in[0];
            state_nxt.hc = pwdata_in[1];
            state_nxt.global_irq_enable = pwdata_in[2];
          end
        end
        default: state_nxt.run = state_nxt.run;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= '{ph: PH_HALT, pc: RST_PC, op_pc: RST_PC,
                   pm_addr: RST_PC, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata_out = state_r.prdata;
  assign pready_out = state_r.pready;
  assign pslverr_out = state_r.pslverr;
  assign pm_addr_out = state_r.pm_addr;
  assign dm_addr_out = state_r.dm_addr;
  assign dm_we_out = state_r.dm_we;
  assign dm_wdata_out = state_r.dm_wdata;
endmodule

`default_nettype wire

// ---- cpu_exec_core_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- mem_model.sv ----
// Program and data memory standing beside the core.
// Assumes the core reads both memories combinationally, same cycle.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk_in,
  input wire logic [14:0] pm_addr_in,
  output logic [7:0] pm_data_out,
  input wire logic [15:0] dm_addr_in,
  input wire logic dm_we_in,
  input wire logic [7:0] dm_wdata_in,
  output logic [7:0] dm_rdata_out
);
  logic [7:0] pm [0:32767];
  logic [7:0] dm [0:65535];
  assign pm_data_out = pm[pm_addr_in];
  assign dm_rdata_out = dm[dm_addr_in];
  // ==========================================================
  // Data writes land on the strobed edge only.
  always @(posedge clk_in) begin
    if (dm_we_in) begin
      dm[dm_addr_in] <= dm_wdata_in;
    end
  end
endmodule
`default_nettype wire

// ---- cpu_exec_properties.sv ----
// Port checks for the execution core, bound to its top module.
// Assumes the APB timing of one setup and one access cycle.
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_props
  import cpu_exec_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic dm_we_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  a_ready_next: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && !penable_in))
    else $error("ready without setup");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_high: assert property (pready_out && paddr_in > 8'h20 |-> pslverr_out)
    else $error("unmapped access without error");
  a_err_low: assert property (pready_out && paddr_in <= 8'h20 |-> !pslverr_out)
    else $error("mapped access with error");
  a_err_alone: assert property (!pready_out |-> !pslverr_out)
    else $error("error outside access");
  a_err_rdata: assert property (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_pc_width: assert property (pready_out && !pwrite_in && paddr_in == REG_PC
    |-> prdata_out[31:15] == 17'h0) else $error("counter wider than 15 bits");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |-> !pready_out && !dm_we_out)
    else $error("outputs active in reset");
  c_err: cover property (pready_out && pslverr_out);
  c_write: cover property (pready_out && pwrite_in);
  c_dm_we: cover property (dm_we_out);
endmodule
bind cpu_exec_core cpu_exec_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .dm_we_out(dm_we_out));
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the execution core with memory model.
// Assumes the core's own opcode layout and APB register map.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpu_exec_pkg::*;
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
  logic [7:0] paddr_in, pm_data, dm_rdata, dm_wdata;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [14:0] pm_addr, vec_addr;
  logic [15:0] dm_addr;
  logic dm_we;
  logic [35:0] r;
  int fail_count = 0;
  int cmp_count = 0;
  // Row: opcode, operand byte, start sum, end sum, carry in, check, flags.
  logic [35:0] rows [17] = '{36'h03053C428, 36'h0B053C43E, 36'h13011010D,
    36'h1BF03C31D, 36'h23053C3E0, 36'h2BFF3CC40, 36'h330505060, 36'h330605050,
    36'h3B0505050, 36'h430506070, 36'h430505050, 36'h7BF00F0F0, 36'h7B0F0F100,
    36'h4B7700780, 36'hA5AF81415, 36'hA6AF81035, 36'hA7AF3CC40};
  cpu_exec_core dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pm_addr_out(pm_addr), .pm_data_in(pm_data),
    .dm_addr_out(dm_addr), .dm_we_out(dm_we), .dm_wdata_out(dm_wdata),
    .dm_rdata_in(dm_rdata), .vector_addr_in(vec_addr));
  mem_model mem (.clk_in(clk_in), .pm_addr_in(pm_addr), .pm_data_out(pm_data),
    .dm_addr_in(dm_addr), .dm_we_in(dm_we), .dm_wdata_in(dm_wdata),
    .dm_rdata_out(dm_rdata));
  always #5 clk_in = ~clk_in;
  // ==========================================================
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask
  // Run until the end loop, then stop and wait for the halted flag.
  task automatic go();
    int n;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (40) @(posedge clk_in);
    apb(1'b1, REG_CTRL, 32'h0);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 20);
    if (rd[0] !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask
  // Program: op, operand, increment, far jump to itself at address 3.
  task automatic prog(input logic [7:0] op, b1, a, input logic c);
    mem.pm[0] = op;
    mem.pm[1] = b1;
    mem.pm[2] = 8'hA1;
    mem.pm[3] = 8'hB0;
    mem.pm[4] = 8'h00;
    mem.pm[5] = 8'h03;
    apb(1'b1, REG_PC, 32'h0);
    apb(1'b1, REG_SUM, {24'h0, a});
    apb(1'b1, REG_FLAGS, {31'h0, c});
    go();
  endtask
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    {psel_in, penable_in, pwrite_in} = 3'h0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    vec_addr = 15'h0100;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, REG_PC, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("reset and unmapped done");
    for (int i = 0; i < 17; i++) begin
      r = rows[i];
      prog(r[35:28], r[27:20], r[19:12], r[3]);
      apb(1'b0, REG_SUM, 32'h0);
      chk(rd, {24'h0, r[11:4]});
      apb(1'b0, REG_FLAGS, 32'h0);
      if (r[2]) chk(rd[1:0], r[1:0]);
    end
    $display("row table done");
    mem.dm[16'h0040] = 8'h00;
    prog(8'h63, 8'h40, 8'h00, 1'b0);
    chk(mem.dm[16'h0040], 8'h08);
    mem.dm[16'h0041] = 8'hFF;
    prog(8'h6F, 8'h41, 8'h00, 1'b0);
    chk(mem.dm[16'h0041], 8'h7F);
    $display("bit set and clear done");
    apb(1'b1, REG_STACK, 32'h30);
    prog(8'hAC, 8'hAF, 8'h5A, 1'b0);
    chk(mem.dm[16'h0030], 8'h5A);
    prog(8'hAD, 8'hAF, 8'h00, 1'b0);
    apb(1'b0, REG_SUM, 32'h0);
    chk(rd, 32'h5B);
    apb(1'b0, REG_STACK, 32'h0);
    chk(rd, 32'h30);
    $display("push and pop done");
    {mem.pm[15'h5000], mem.pm[15'h5001], mem.pm[15'h5002]} = 24'hB80123;
    {mem.pm[15'h5123], mem.pm[15'h5124], mem.pm[15'h5125]} = 24'hB05123;
    apb(1'b1, REG_PC, 32'h5000);
    go();
    apb(1'b0, REG_PC, 32'h0);
    chk(rd, 32'h5123);
    $display("page jump done");
    finish_test();
  end
endmodule
`default_nettype wire
